/* hw/rtm_regs.svh */
// register indices, field positions and reset values of the reload timer
`ifndef RTM_REGS_SVH
`define RTM_REGS_SVH
// register indices; byte address is four times the index
`define RTM_IDX_DIV 18'h04240
`define RTM_IDX_RELOAD 18'h04242
`define RTM_IDX_COUNT 18'h04244
`define RTM_IDX_CTRL 18'h04246
// control field positions
`define RTM_CTL_RUN 0
`define RTM_CTL_STROBE 1
`define RTM_CTL_ONESHOT 4
`define RTM_CTL_MODE_LO 8
`define RTM_CTL_MODE_HI 9
`define RTM_CTL_LEVEL 10
// reset values, reserved tap code and constants
`define RTM_DIV_RST 4'h0
`define RTM_DIV_RESERVED 4'hF
`define RTM_RELOAD_RST 16'h0000
`define RTM_COUNT_RST 16'hFFFF
`define RTM_LEVEL_RST 1'h1
`define RTM_ZERO16 16'h0000
`define RTM_ONE16 16'h0001
// bus answers
`define RTM_RESP_OKAY 2'h0
`define RTM_RESP_SLVERR 2'h2
`endif

/* hw/rtm_pkg.sv */
// types shared by the reload timer files
package rtm_pkg;
  // source and mode select, codes follow declaration order
  typedef enum logic [1:0] {
    RTM_SRC_INT,
    RTM_SRC_EXT,
    RTM_PULSE,
    RTM_RSVD
  } rtm_mode_t;
  typedef logic [15:0] rtm_word_t;
endpackage

/* hw/rtm_prescaler.sv */
// free running prescaler with a selectable power-of-two tap
`timescale 1ns/1ns
`include "rtm_regs.svh"
module rtm_prescaler import rtm_pkg::*; #(
  parameter int DIV_W = 4,
  parameter int CNT_W = 14
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // tap select and tick out
  input wire logic [DIV_W-1:0] divider_code,
  output logic tick
);
  logic [CNT_W-1:0] cnt_ff; // free running count
  logic [CNT_W-1:0] nxt_cnt;
  logic tick_ff; // registered tap pulse
  logic nxt_tick;
  logic [CNT_W-1:0] mask; // low bits that must all be ones

  // one pulse every 2^code clocks; reserved code never ticks
  always_comb begin
    nxt_cnt = cnt_ff + 1'b1;
    mask = ~({CNT_W{1'b1}} << divider_code);
    if (divider_code == `RTM_DIV_RESERVED) begin
      nxt_tick = 1'b0;
    end else begin
      nxt_tick = (cnt_ff & mask) == mask;
    end
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule // rtm_prescaler

/* hw/rtm_timer.sv */
// one reload timer channel with an axi4-lite register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rtm_regs.svh"
// Overview of operation
// - prescaler tap selected by 4-bit code
// - read/write 16-bit reload value, resets zero
// - read-only live count, resets all ones
// - level bit selects external input polarity
// - mode selects internal, external, pulse width
module rtm_timer import rtm_pkg::*; #(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external clock or pulse pin, and underflow pulse
  input wire logic ext_clk_pin,
  output logic underflow_ff
);
  // ---- bus state ----
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [ADDR_W-3:0] aw_idx_ff, nxt_aw_idx; // held write index
  logic [15:0] wdata_ff, nxt_wdata; // held write data
  logic [1:0] wstrb_ff, nxt_wstrb; // only two lanes matter
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_do; // both halves of a write are held
  logic [ADDR_W-3:0] ar_idx;
  // ---- timer registers ----
  logic [3:0] div_ff, nxt_div;
  rtm_word_t reload_ff, nxt_reload, count_ff, nxt_count;
  logic level_ff, nxt_level, oneshot_ff, nxt_oneshot, run_ff, nxt_run;
  rtm_mode_t mode_ff, nxt_mode;
  logic preset; // reload strobe written as one
  logic nxt_underflow;
  // ---- input sync and tick ----
  logic sync1_ff, sync2_ff, pin_prev_ff; // synchroniser, last pin
  logic act_now; // pin at active level
  logic ext_edge; // pin edge into active level, not a level flip
  logic pre_tick; // prescaler tap pulse
  logic cnt_tick; // counter step this cycle

  rtm_prescaler #(.DIV_W(4), .CNT_W(14)) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .divider_code(div_ff),
    .tick(pre_tick)
  );

  // ---- axi4-lite next state ----
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_aw_idx = aw_idx_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    ar_idx = s_axi_araddr[ADDR_W-1:2];
    wr_do = aw_have_ff && w_have_ff && !bvalid_ff;
    // address and data taken independently, either order
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata[15:0];
      nxt_wstrb = s_axi_wstrb[1:0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_do) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      case (aw_idx_ff)
        `RTM_IDX_DIV, `RTM_IDX_RELOAD,
        `RTM_IDX_COUNT, `RTM_IDX_CTRL: nxt_bresp = `RTM_RESP_OKAY;
        default: nxt_bresp = `RTM_RESP_SLVERR; // unmapped
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RTM_RESP_OKAY;
      nxt_rdata = '0; // upper half always zero
      case (ar_idx)
        `RTM_IDX_DIV: nxt_rdata[3:0] = div_ff;
        `RTM_IDX_RELOAD: nxt_rdata[15:0] = reload_ff;
        `RTM_IDX_COUNT: nxt_rdata[15:0] = count_ff;
        `RTM_IDX_CTRL: begin
          // strobe bit and reserved bits read zero
          nxt_rdata[`RTM_CTL_RUN] = run_ff;
          nxt_rdata[`RTM_CTL_ONESHOT] = oneshot_ff;
          nxt_rdata[`RTM_CTL_MODE_HI:`RTM_CTL_MODE_LO] = mode_ff;
          nxt_rdata[`RTM_CTL_LEVEL] = level_ff;
        end
        default: nxt_rresp = `RTM_RESP_SLVERR;
      endcase
    end
    // readies come from next state so no second beat slips in
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // ---- axi4-lite registers ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_idx_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RTM_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RTM_RESP_OKAY;
      rdata_ff <= '0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      aw_idx_ff <= nxt_aw_idx;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---- pin synchroniser, only stage two and its delayed copy are looked at ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_clk_pin;
      sync2_ff <= sync1_ff;
      pin_prev_ff <= sync2_ff;
    end
  end

  // ---- tick source and timer next state ----
  always_comb begin
    act_now = level_ff ? sync2_ff : !sync2_ff;
    ext_edge = act_now && (sync2_ff != pin_prev_ff);
    case (mode_ff)
      RTM_SRC_INT: cnt_tick = pre_tick;
      RTM_SRC_EXT: cnt_tick = ext_edge;
      RTM_PULSE: cnt_tick = pre_tick && act_now;
      default: cnt_tick = 1'b0; // reserved mode never counts
    endcase
    cnt_tick = cnt_tick && run_ff;
    nxt_div = div_ff;
    nxt_reload = reload_ff;
    nxt_level = level_ff;
    nxt_mode = mode_ff;
    nxt_oneshot = oneshot_ff;
    nxt_run = run_ff;
    nxt_count = count_ff;
    nxt_underflow = 1'b0;
    preset = 1'b0;
    // underflow reloads; a one-shot run stops itself
    if (cnt_tick) begin
      if (count_ff == `RTM_ZERO16) begin
        nxt_count = reload_ff;
        nxt_underflow = 1'b1;
        if (oneshot_ff) begin
          nxt_run = 1'b0;
        end
      end else begin
        nxt_count = count_ff - `RTM_ONE16;
      end
    end
    // software write; a run set wins over the one-shot stop
    if (wr_do) begin
      case (aw_idx_ff)
        `RTM_IDX_DIV: if (wstrb_ff[0]) nxt_div = wdata_ff[3:0];
        `RTM_IDX_RELOAD: begin
          if (wstrb_ff[0]) nxt_reload[7:0] = wdata_ff[7:0];
          if (wstrb_ff[1]) nxt_reload[15:8] = wdata_ff[15:8];
        end
        `RTM_IDX_CTRL: begin
          if (wstrb_ff[0]) begin
            nxt_run = wdata_ff[`RTM_CTL_RUN];
            nxt_oneshot = wdata_ff[`RTM_CTL_ONESHOT];
            preset = wdata_ff[`RTM_CTL_STROBE];
          end
          if (wstrb_ff[1]) begin
            nxt_level = wdata_ff[`RTM_CTL_LEVEL];
            nxt_mode = rtm_mode_t'(
              wdata_ff[`RTM_CTL_MODE_HI:`RTM_CTL_MODE_LO]);
          end
        end
        default: ; // count register ignores writes
      endcase
    end
    // strobe reload beats a same-cycle step
    if (preset) begin
      nxt_count = reload_ff;
    end
  end

  // ---- timer registers ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= `RTM_DIV_RST;
      reload_ff <= `RTM_RELOAD_RST;
      count_ff <= `RTM_COUNT_RST;
      level_ff <= `RTM_LEVEL_RST;
      mode_ff <= RTM_SRC_INT;
      oneshot_ff <= 1'b0;
      run_ff <= 1'b0;
      underflow_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      reload_ff <= nxt_reload;
      count_ff <= nxt_count;
      level_ff <= nxt_level;
      mode_ff <= nxt_mode;
      oneshot_ff <= nxt_oneshot;
      run_ff <= nxt_run;
      underflow_ff <= nxt_underflow;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // ---- checks ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reserved_tap: assert property (
    $past(div_ff) == `RTM_DIV_RESERVED && $past(div_ff, 2) ==
    `RTM_DIV_RESERVED |-> !pre_tick)
    else $error("reserved tap produced a tick");
  chk_reload_write: assert property (
    $past(aresetn) && !$stable(reload_ff) |-> $past(wr_do) &&
    $past(aw_idx_ff) == `RTM_IDX_RELOAD)
    else $error("reload value changed without a write");
  chk_count_cause: assert property (
    $past(aresetn) && !$stable(count_ff) |-> $past(cnt_tick) || $past(preset))
    else $error("count changed without tick or strobe");
  chk_ext_step: assert property (
    mode_ff == RTM_SRC_EXT && run_ff && ext_edge && !preset &&
    count_ff != `RTM_ZERO16 |=> count_ff == $past(count_ff) - `RTM_ONE16)
    else $error("external edge did not step the count");
  chk_rsvd_mode: assert property (
    mode_ff == RTM_RSVD |-> !cnt_tick)
    else $error("reserved mode counted");
  chk_strobe_load: assert property (
    preset |=> count_ff == $past(reload_ff))
    else $error("strobe did not reload the count");
  chk_oneshot_stop: assert property (
    oneshot_ff && cnt_tick && count_ff == `RTM_ZERO16 && !wr_do
    |=> !run_ff ##1 !underflow_ff)
    else $error("one-shot did not stop at underflow");
  chk_write_answer: assert property (
    wr_do |=> bvalid_ff)
    else $error("write got no response");

  cov_underflow: cover property (run_ff ##1 underflow_ff);
  cov_pulse_count: cover property (mode_ff == RTM_PULSE && cnt_tick);
  cov_strobe: cover property (preset ##1 run_ff);
endmodule // rtm_timer

/* sim/rtm_pin_model.sv */
// behavioural source for the external clock pin
`timescale 1ns/1ns
module rtm_pin_model import rtm_pkg::*; (
  // clock
  input wire logic aclk,
  // pin into the timer
  output logic ext_clk_pin
);
  // rests low; a real pin source holds its level between bursts
  initial ext_clk_pin = 1'h0;
  // set after an edge, then hold for a number of cycles
  task automatic drive(input logic v, input int hold);
    @(posedge aclk);
    ext_clk_pin <= v;
    repeat (hold) @(posedge aclk);
  endtask
endmodule // rtm_pin_model

/* sim/tb.sv */
// self-checking bench for the reload timer channel
`timescale 1ns/1ns
`include "rtm_regs.svh"
module tb import rtm_pkg::*; ();
  localparam int LIM = 40000; // bound of every wait
  typedef struct packed {
    logic [17:0] i;
    logic [3:0] s;
    logic [15:0] w;
    logic [15:0] r;
    logic [1:0] p;
  } rtm_row_t;
  logic aclk, aresetn, awv, wv, brdy, arv, rrdy;
  logic awr, wr, bv, arr, rv, ext_pin, uf;
  logic [19:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] br, rr;
  int fail_count, checks_done;
  rtm_row_t rows [7];
  // tap codes and reloads for period tests
  logic [3:0] pc [3] = '{4'h0, 4'h3, 4'hE};
  logic [15:0] pr [3] = '{16'h0005, 16'h0002, 16'h0000};
  rtm_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .ext_clk_pin(ext_pin), .underflow_ff(uf));
  rtm_pin_model pin (.aclk(aclk), .ext_clk_pin(ext_pin));
  // 50 MHz clock
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // a used-up bound ends the run
  task automatic tmo(input int n);
    if (n >= LIM) begin
      fail_count++;
      wrap_up();
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wrs(input logic [17:0] i, input logic [15:0] d,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= {i, 2'h0};
    wd <= {16'h0000, d};
    ws <= s;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 1'h0;
      if (wv && wr) wv <= 1'h0;
    end while (!(brdy && bv) && n < LIM);
    r = br;
    brdy <= 1'h0;
    tmo(n);
  endtask
  task automatic wreg(input logic [17:0] i, input logic [15:0] d);
    logic [1:0] r;
    wrs(i, d, 4'hF, r);
  endtask
  task automatic rd_reg(input logic [17:0] i, output logic [15:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= {i, 2'h0};
    arv <= 1'h1;
    rrdy <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 1'h0;
    end while (!(rrdy && rv) && n < LIM);
    d = rd[15:0];
    r = rr;
    rrdy <= 1'h0;
    tmo(n);
  endtask
  task automatic rchk(input logic [17:0] i, input logic [15:0] e);
    logic [15:0] d;
    logic [1:0] r;
    rd_reg(i, d, r);
    chk(d, e);
  endtask
  // cycles up to the next underflow pulse
  task automatic wuf(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (uf !== 1'h1 && n < LIM);
    tmo(n);
  endtask
  task automatic rst_chk();
    rchk(`RTM_IDX_DIV, 16'h0000);
    rchk(`RTM_IDX_RELOAD, 16'h0000);
    rchk(`RTM_IDX_COUNT, 16'hFFFF);
    rchk(`RTM_IDX_CTRL, 16'h0400);
  endtask
  initial begin
    int n, m;
    logic [15:0] d;
    logic [1:0] r;
    aresetn = 1'h0;
    {awv, wv, brdy, arv, rrdy} = 5'h00;
    awa = 20'h00000;
    ara = 20'h00000;
    wd = 32'h00000000;
    ws = 4'hF;
    fail_count = 0;
    checks_done = 0;
    // reserved bits, lane strobes, read-only count, strobe reload
    rows = '{'{`RTM_IDX_DIV, 4'hF, 16'hFFF5, 16'h0005, `RTM_RESP_OKAY},
      '{`RTM_IDX_RELOAD, 4'hF, 16'hA5C3, 16'hA5C3, `RTM_RESP_OKAY},
      '{`RTM_IDX_RELOAD, 4'h1, 16'h7711, 16'hA511, `RTM_RESP_OKAY},
      '{`RTM_IDX_COUNT, 4'hF, 16'h1234, 16'hFFFF, `RTM_RESP_OKAY},
      '{`RTM_IDX_CTRL, 4'hF, 16'hFCF2, 16'h0410, `RTM_RESP_OKAY},
      '{`RTM_IDX_COUNT, 4'hF, 16'h0000, 16'hA511, `RTM_RESP_OKAY},
      '{18'h04248, 4'hF, 16'h1111, 16'h0000, `RTM_RESP_SLVERR}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rst_chk();
    $display("done: reset values");
    foreach (rows[k]) begin
      wrs(rows[k].i, rows[k].w, rows[k].s, r);
      chk(16'(r), 16'(rows[k].p));
      rd_reg(rows[k].i, d, r);
      chk(16'(r), 16'(rows[k].p));
      if (r === `RTM_RESP_OKAY) begin
        chk(d, rows[k].r);
      end
    end
    $display("done: register rows");
    // underflow period is (reload+1) taps of 2^code cycles
    for (m = 0; m < 3; m++) begin
      wreg(`RTM_IDX_DIV, {12'h000, pc[m]});
      wreg(`RTM_IDX_RELOAD, pr[m]);
      wreg(`RTM_IDX_CTRL, 16'h0403);
      wuf(n);
      wuf(n);
      chk(16'(n), 16'((pr[m] + 16'h1) << pc[m]));
    end
    $display("done: tap periods");
    // one-shot stops itself and leaves the reload in the count
    wreg(`RTM_IDX_DIV, 16'h0000);
    wreg(`RTM_IDX_RELOAD, 16'h0002);
    wreg(`RTM_IDX_CTRL, 16'h0413);
    wuf(n);
    repeat (4) @(posedge aclk);
    rchk(`RTM_IDX_CTRL, 16'h0410);
    rchk(`RTM_IDX_COUNT, 16'h0002);
    $display("done: one-shot");
    // pin idle: only internal mode with a live tap counts
    wreg(`RTM_IDX_RELOAD, 16'h0050);
    for (m = 0; m < 5; m++) begin
      wreg(`RTM_IDX_DIV, {12'h000, (m == 4) ? 4'hF : 4'h0});
      wreg(`RTM_IDX_CTRL, {6'h01, m[1:0], 8'h03});
      repeat (10) @(posedge aclk);
      rd_reg(`RTM_IDX_COUNT, d, r);
      chk(16'(d !== 16'h0050), 16'(m == 0));
    end
    $display("done: mode codes");
    // one step per edge into the active level
    for (m = 0; m < 2; m++) begin
      wreg(`RTM_IDX_RELOAD, 16'h0009);
      wreg(`RTM_IDX_CTRL, {5'h00, m[0], 10'h103});
      pin.drive(1'h1, 6);
      rchk(`RTM_IDX_COUNT, m ? 16'h0008 : 16'h0009);
      pin.drive(1'h0, 6);
      rchk(`RTM_IDX_COUNT, 16'h0008);
    end
    $display("done: external edges");
    // width of a high pulse in undivided ticks, with some sync slack
    wreg(`RTM_IDX_DIV, 16'h0000);
    wreg(`RTM_IDX_RELOAD, 16'h0100);
    wreg(`RTM_IDX_CTRL, 16'h0603);
    pin.drive(1'h1, 20);
    pin.drive(1'h0, 8);
    rd_reg(`RTM_IDX_COUNT, d, r);
    chk(16'((d >= 16'h00E9) && (d <= 16'h00ED)), 16'h0001);
    $display("done: pulse width");
    // reset again while running
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rst_chk();
    $display("done: second reset");
    wrap_up();
  end
endmodule // tb
